// File: hw/host_port_media_pkg.sv
// Constants and carriers for the host port media interface config block.
// Assumes a 40 MHz core clock and a link receive clock from the far side.
package host_port_media_pkg;
    // Register indices and their word byte addresses
    localparam logic [15:0] LINK_CONTROL_IDX = 16'h3300;
    localparam logic [15:0] INTERFACE_SELECT_IDX = 16'h3301;
    localparam logic [15:0] INBAND_STATUS_IDX = 16'h3303;
    localparam logic [15:0] LINK_CONTROL_ADDR = {LINK_CONTROL_IDX[13:0], 2'h0};
    localparam logic [15:0] INTERFACE_SELECT_ADDR =
        {INTERFACE_SELECT_IDX[13:0], 2'h0};
    localparam logic [15:0] INBAND_STATUS_ADDR =
        {INBAND_STATUS_IDX[13:0], 2'h0};
    // Link control fields
    localparam int BIT_DUPLEX = 6;
    localparam int BIT_TX_FC = 5;
    localparam int BIT_SPEED_100 = 4;
    localparam int BIT_RX_FC = 3;
    localparam logic [7:0] LINK_CONTROL_RST = 8'h50;
    localparam logic [7:0] LINK_CONTROL_WMASK = 8'h7F;
    // Interface select fields
    localparam int BIT_GIG = 6;
    localparam int BIT_IG_DELAY = 4;
    localparam int BIT_EG_DELAY = 3;
    localparam int BIT_ROLE = 2;
    localparam logic [7:0] INTERFACE_SELECT_RST = 8'h08;
    // In-band status: upper nibble is plain storage
    localparam logic [3:0] INBAND_RSVD_RST = 4'h0;
    // Interface type codes
    localparam logic [1:0] IFACE_MII = 2'h0;
    localparam logic [1:0] IFACE_RMII = 2'h1;
    localparam logic [1:0] IFACE_RSVD = 2'h2;
    localparam logic [1:0] IFACE_RGMII = 2'h3;
    // Speed codes, shared with the in-band clock speed code
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    // Clock delay added by the pad delay cell, picoseconds minimum
    localparam int CLOCK_DELAY_MIN_PS = 1500;
    // Core cycles after reset release at which straps are taken
    localparam logic [1:0] STRAP_LOAD_CYCLE = 2'h2;
    localparam logic [1:0] STRAP_DONE_CYCLE = 2'h3;
    // Settings handed to the port MAC
    typedef struct packed {
        logic full_duplex;
        logic tx_fc_en;
        logic rx_fc_en;
        logic [1:0] speed;
        logic [1:0] iface;
    } mac_cfg_t;
    // In-band status word as carried on rxd during idle
    typedef struct packed {
        logic duplex;
        logic [1:0] clk_speed;
        logic link_up;
    } inband_t;
endpackage : host_port_media_pkg

// File: hw/host_port_media_config.sv
// Config and status logic for the host port media interface.
// Assumes an APB master on clock and an RGMII receive clock on link_clk.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module host_port_media_config
    import host_port_media_pkg::*;
(
    // Core clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration straps, pins
    input wire logic strap_gig,
    input wire logic strap_role,
    input wire logic [1:0] strap_iface,
    // Settings towards the port MAC and pads
    output mac_cfg_t mac_cfg,
    output logic ingress_clock_delay,
    output logic egress_clock_delay,
    output logic rxc_out_en,
    output logic txc_out_en,
    output logic inband_link_status_en,
    // Link receive side, on the far side's clock
    input wire logic link_clk,
    input wire logic link_rx_ctl,
    input wire logic [3:0] link_rxd
);

    // Register storage
    logic [7:0] ctrl0_reg;
    logic [7:0] ctrl1_reg;
    logic [3:0] ctrl3_rsvd_reg;
    inband_t ib_status_reg;
    // Strap synchroniser and loader
    logic [3:0] strap_s1_reg;
    logic [3:0] strap_s2_reg;
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    // APB answer flops
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    // Output flops
    mac_cfg_t mac_cfg_reg;
    logic ig_dly_reg;
    logic eg_dly_reg;
    logic rxc_oe_reg;
    logic txc_oe_reg;
    logic ib_en_reg;
    // Handshake, core side
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_s3_reg;
    logic ack_reg;
    // Link domain
    logic [1:0] lk_rst_reg;
    logic en_s1_reg;
    logic en_s2_reg;
    logic lk_ctl_reg;
    logic [3:0] lk_rxd_reg;
    inband_t lk_status_reg;
    inband_t lk_hold_reg;
    logic lk_req_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;

    // Speed the MAC runs at; the 10/100 bit is moot at gigabit
    function automatic logic [1:0] speed_of(input logic gig,
                                            input logic fast);
        if (gig)
            return SPEED_1000;
        return fast ? SPEED_100 : SPEED_10;
    endfunction : speed_of

    // Address decode and transfer phases
    wire hit0 = (paddr == LINK_CONTROL_ADDR);
    wire hit1 = (paddr == INTERFACE_SELECT_ADDR);
    wire hit3 = (paddr == INBAND_STATUS_ADDR);
    wire hit_any = hit0 | hit1 | hit3;
    wire access_done = psel & penable & pready_reg;
    wire wr_ok = access_done & pwrite & pstrb[0] & ~pslverr_reg;
    wire wr0 = wr_ok & hit0;
    wire wr1 = wr_ok & hit1;
    wire wr3 = wr_ok & hit3;
    // One wait state; held off until straps are in
    wire pready_next = psel & penable & ~pready_reg & strap_done_reg;
    wire [7:0] rd_byte = hit0 ? ctrl0_reg :
                         hit1 ? ctrl1_reg :
                         hit3 ? {ctrl3_rsvd_reg, ib_status_reg} : 8'h00;
    wire [31:0] prdata_next = (pready_next & ~pwrite) ?
                              {24'h000000, rd_byte} : 32'h00000000;
    wire pslverr_next = pready_next & ~hit_any;
    // Reserved type code is refused, field keeps its value
    wire iface_wr_ok = (pwdata[1:0] != IFACE_RSVD);
    wire [1:0] iface_next = iface_wr_ok ? pwdata[1:0] : ctrl1_reg[1:0];
    wire [7:0] ctrl1_wdata = {pwdata[7:2], iface_next};
    // Strap load point
    wire strap_load = (strap_cnt_reg == STRAP_LOAD_CYCLE);

    // Decoded settings
    wire [1:0] iface = ctrl1_reg[1:0];
    wire role = ctrl1_reg[BIT_ROLE];
    wire is_mii = (iface == IFACE_MII);
    wire is_rmii = (iface == IFACE_RMII);
    wire is_rgmii = (iface == IFACE_RGMII);
    mac_cfg_t cfg_next;
    assign cfg_next.full_duplex = ctrl0_reg[BIT_DUPLEX];
    assign cfg_next.tx_fc_en = ctrl0_reg[BIT_TX_FC];
    assign cfg_next.rx_fc_en = ctrl0_reg[BIT_RX_FC];
    assign cfg_next.speed = speed_of(ctrl1_reg[BIT_GIG],
                                     ctrl0_reg[BIT_SPEED_100]);
    assign cfg_next.iface = iface;
    // MII as PHY drives both clocks; RMII drives only the refclk pin
    wire rxc_oe_next = (is_mii | is_rmii) & ~role;
    wire txc_oe_next = is_mii & ~role;
    wire ib_en_next = is_rgmii & role;

    // Strap pins: two flops before use
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_s1_reg <= 4'h0;
            strap_s2_reg <= 4'h0;
        end
        else
        begin
            strap_s1_reg <= {strap_gig, strap_role, strap_iface};
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // Count off the sync delay, then take straps once
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end
        else
        begin
            if (!strap_done_reg)
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            strap_done_reg <= (strap_cnt_reg == STRAP_DONE_CYCLE) |
                              strap_done_reg;
        end
    end

    // Link control register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ctrl0_reg <= LINK_CONTROL_RST;
        else if (wr0)
            ctrl0_reg <= pwdata[7:0] & LINK_CONTROL_WMASK;
    end

    // Interface select; strap-dependent bits loaded after reset
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ctrl1_reg <= INTERFACE_SELECT_RST;
        else if (strap_load)
        begin
            ctrl1_reg[BIT_GIG] <= strap_s2_reg[3];
            ctrl1_reg[BIT_ROLE] <= strap_s2_reg[2];
            ctrl1_reg[1:0] <= strap_s2_reg[1:0];
        end
        else if (wr1)
            ctrl1_reg <= ctrl1_wdata;
    end

    // Spare storage in the status register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ctrl3_rsvd_reg <= INBAND_RSVD_RST;
        else if (wr3)
            ctrl3_rsvd_reg <= pwdata[7:4];
    end

    // APB answer
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Settings to MAC and pads, one cycle behind the registers
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mac_cfg_reg <= '0;
            ig_dly_reg <= 1'b0;
            eg_dly_reg <= 1'b0;
            rxc_oe_reg <= 1'b0;
            txc_oe_reg <= 1'b0;
            ib_en_reg <= 1'b0;
        end
        else
        begin
            mac_cfg_reg <= cfg_next;
            ig_dly_reg <= ctrl1_reg[BIT_IG_DELAY];
            eg_dly_reg <= ctrl1_reg[BIT_EG_DELAY];
            rxc_oe_reg <= rxc_oe_next & strap_done_reg;
            txc_oe_reg <= txc_oe_next & strap_done_reg;
            ib_en_reg <= ib_en_next;
        end
    end

    // Status word crossing in: toggle request, data held stable
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_s3_reg <= 1'b0;
            ack_reg <= 1'b0;
            ib_status_reg <= '0;
        end
        else
        begin
            req_s1_reg <= lk_req_reg;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            ack_reg <= req_s2_reg;
            if (req_s2_reg != req_s3_reg)
                ib_status_reg <= lk_hold_reg;
        end
    end

    // Link domain reset: asserts at once, releases on link_clk
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
            lk_rst_reg <= 2'h0;
        else
            lk_rst_reg <= {lk_rst_reg[0], 1'b1};
    end
    wire lk_rst_n = lk_rst_reg[1];

    // Enable and ack into the link domain
    always_ff @(posedge link_clk or negedge lk_rst_n)
    begin
        if (!lk_rst_n)
        begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end
        else
        begin
            en_s1_reg <= ib_en_reg;
            en_s2_reg <= en_s1_reg;
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // Between frames rxd carries duplex, clock speed and link
    // Only the rising-edge half of the DDR pins is looked at
    wire lk_idle = ~lk_ctl_reg;
    wire lk_take = en_s2_reg & lk_idle;
    wire lk_free = (lk_req_reg == ack_s2_reg);
    wire lk_send = lk_free & (lk_hold_reg != lk_status_reg);
    always_ff @(posedge link_clk or negedge lk_rst_n)
    begin
        if (!lk_rst_n)
        begin
            lk_ctl_reg <= 1'b0;
            lk_rxd_reg <= 4'h0;
            lk_status_reg <= '0;
            lk_hold_reg <= '0;
            lk_req_reg <= 1'b0;
        end
        else
        begin
            lk_ctl_reg <= link_rx_ctl;
            lk_rxd_reg <= link_rxd;
            if (lk_take)
                lk_status_reg <= lk_rxd_reg;
            if (lk_send)
            begin
                lk_hold_reg <= lk_status_reg;
                lk_req_reg <= ~lk_req_reg;
            end
        end
    end

    // Ports from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mac_cfg = mac_cfg_reg;
    assign ingress_clock_delay = ig_dly_reg;
    assign egress_clock_delay = eg_dly_reg;
    assign rxc_out_en = rxc_oe_reg;
    assign txc_out_en = txc_oe_reg;
    assign inband_link_status_en = ib_en_reg;

    // Checks on the core clock
    sequence s_wr0;
        wr0;
    endsequence
    sequence s_wr1_ok;
        wr1 & iface_wr_ok & ~strap_load;
    endsequence

    AST_DUPLEX: assert property (@(posedge clock) disable iff (!arst_n)
        s_wr0 |-> ##2 mac_cfg.full_duplex == $past(pwdata[6], 2))
        else $error("duplex setting not applied");
    AST_TX_FC: assert property (@(posedge clock) disable iff (!arst_n)
        s_wr0 |-> ##2 mac_cfg.tx_fc_en == $past(pwdata[5], 2))
        else $error("tx flow control setting not applied");
    AST_RX_FC: assert property (@(posedge clock) disable iff (!arst_n)
        s_wr0 |-> ##2 mac_cfg.rx_fc_en == $past(pwdata[3], 2))
        else $error("rx flow control setting not applied");
    // Qualified by strap_done so the reset image of mac_cfg is not judged
    AST_SPEED_LOW: assert property (@(posedge clock) disable iff (!arst_n)
        strap_done_reg && !ctrl1_reg[BIT_GIG] ##1 !ctrl1_reg[BIT_GIG] |->
        mac_cfg.speed == ($past(ctrl0_reg[BIT_SPEED_100]) ? SPEED_100
                          : SPEED_10))
        else $error("10/100 speed wrong");
    AST_SPEED_GIG: assert property (@(posedge clock) disable iff (!arst_n)
        s_wr1_ok ##1 ctrl1_reg[BIT_GIG] |-> ##1 mac_cfg.speed == SPEED_1000)
        else $error("gigabit speed not applied");
    AST_DELAYS: assert property (@(posedge clock) disable iff (!arst_n)
        s_wr1_ok |-> ##2 ingress_clock_delay == $past(pwdata[4], 2) &&
        egress_clock_delay == $past(pwdata[3], 2))
        else $error("clock delay setting not applied");
    AST_CLK_DIR: assert property (@(posedge clock) disable iff (!arst_n)
        strap_done_reg ##1 1 |->
        rxc_out_en == (!$past(ctrl1_reg[1]) && !$past(ctrl1_reg[BIT_ROLE])) &&
        txc_out_en == ($past(ctrl1_reg[1:0]) == IFACE_MII &&
        !$past(ctrl1_reg[BIT_ROLE])))
        else $error("clock direction wrong");
    AST_IB_EN: assert property (@(posedge clock) disable iff (!arst_n)
        s_wr1_ok |-> ##2 inband_link_status_en ==
        ($past(pwdata[2], 2) && $past(iface_next, 2) == IFACE_RGMII))
        else $error("in-band enable wrong");
    AST_IFACE_RSVD: assert property (@(posedge clock) disable iff (!arst_n)
        wr1 & ~iface_wr_ok |=> $stable(ctrl1_reg[1:0]))
        else $error("reserved interface code taken");
    AST_STRAP: assert property (@(posedge clock) disable iff (!arst_n)
        strap_load |=> ctrl1_reg[1:0] == $past(strap_s2_reg[1:0]) &&
        ctrl1_reg[BIT_GIG] == $past(strap_s2_reg[3]))
        else $error("strap not loaded");
    AST_STATUS_XFER: assert property (@(posedge clock) disable iff (!arst_n)
        $changed(req_s2_reg) |=> ib_status_reg == $past(lk_hold_reg))
        else $error("in-band status not reported");

    // Check on the link clock
    AST_IB_TAKE: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
        lk_take |=> lk_status_reg == $past(lk_rxd_reg))
        else $error("in-band word not captured");

endmodule : host_port_media_config

// File: verif/phy_inband_model.sv
// Far-side RGMII PHY model: sends in-band status words between frames.
// Assumes the bench makes link_clk and sets the word and frame flag.
`timescale 1ns/1ps
module phy_inband_model
(
    // Link clock from the bench
    input wire logic link_clk,
    // Bench controls
    input wire logic in_frame,
    input wire logic [3:0] word,
    // Receive lines towards the port
    output logic link_rx_ctl,
    output logic [3:0] link_rxd
);
    // Frame filler, changes every cycle so a stale value never matches
    logic [3:0] fill = 4'h0;
    // Launch on the falling edge so the port samples settled lines
    always @(negedge link_clk)
    begin
        fill <= fill + 4'h3;
        link_rx_ctl <= in_frame;
        // Idle carries {duplex, speed, link}
        link_rxd <= in_frame ? fill : word;
    end
endmodule : phy_inband_model

// File: verif/tb_host_port_media_config.sv
// Self-checking bench for the host port media config block.
// Assumes an APB master here and the PHY model on the link side.
`timescale 1ns/1ps
module tb_host_port_media_config import host_port_media_pkg::*;;
    logic clock, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, word;
    logic strap_gig, strap_role, link_clk, link_rx_ctl, in_frame;
    logic [1:0] strap_iface;
    logic [3:0] link_rxd;
    mac_cfg_t mac_cfg;
    logic ig_dly, eg_dly, rxc_oe, txc_oe, ib_en;
    int bad_count = 0;
    int checks = 0;
    // One row: write, then expected readback, MAC settings and pads
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [31:0] rdata;
        logic [6:0] mac;
        logic [4:0] pads;
    } row_t;
    row_t rows [11] = '{
        '{LINK_CONTROL_ADDR, 8'hFF, 32'h7F, 7'h77, 5'h09},
        '{INTERFACE_SELECT_ADDR, 8'h4F, 32'h4F, 7'h7B, 5'h09},
        '{LINK_CONTROL_ADDR, 8'h28, 32'h28, 7'h3B, 5'h09},
        '{INTERFACE_SELECT_ADDR, 8'h18, 32'h18, 7'h30, 5'h1E},
        '{INTERFACE_SELECT_ADDR, 8'h0C, 32'h0C, 7'h30, 5'h08},
        '{INTERFACE_SELECT_ADDR, 8'h01, 32'h01, 7'h31, 5'h04},
        '{INTERFACE_SELECT_ADDR, 8'h05, 32'h05, 7'h31, 5'h00},
        // Reserved type code leaves the field alone
        '{INTERFACE_SELECT_ADDR, 8'h02, 32'h01, 7'h31, 5'h04},
        '{INTERFACE_SELECT_ADDR, 8'hA3, 32'hA3, 7'h33, 5'h00},
        '{LINK_CONTROL_ADDR, 8'h10, 32'h10, 7'h07, 5'h00},
        '{INTERFACE_SELECT_ADDR, 8'h07, 32'h07, 7'h07, 5'h01}
    };
    logic [3:0] ib_words [3] = '{4'hB, 4'h5, 4'h8};
    logic [31:0] rd;
    logic err;

    host_port_media_config host_port_media_config_inst (
        .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_gig(strap_gig), .strap_role(strap_role),
        .strap_iface(strap_iface), .mac_cfg(mac_cfg),
        .ingress_clock_delay(ig_dly), .egress_clock_delay(eg_dly),
        .rxc_out_en(rxc_oe), .txc_out_en(txc_oe),
        .inband_link_status_en(ib_en), .link_clk(link_clk),
        .link_rx_ctl(link_rx_ctl), .link_rxd(link_rxd));

    phy_inband_model phy_inband_model_inst (
        .link_clk(link_clk), .in_frame(in_frame), .word(word),
        .link_rx_ctl(link_rx_ctl), .link_rxd(link_rxd));

    // Core clock, 25 ns
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Link clock, 125 ns, phase unrelated to the core clock
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic chk(input string what, input logic [31:0] got,
        input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; psel stays up so a setup may follow at once
    task automatic apb(input logic wr, input logic [15:0] a,
        input logic [7:0] d, input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        // No wait count assumed; only the watchdog ends a hang
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
    endtask : apb

    task automatic idle;
        psel <= 1'b0;
        @(posedge clock);
    endtask : idle

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
        idle;
    endtask : wr

    task automatic rdc(input string what, input logic [15:0] a,
        input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 8'h00, 4'h0);
        idle;
        chk(what, rd, exp);
        chk("pslverr", {31'h0, err}, {31'h0, eexp});
    endtask : rdc

    // Outputs settle one edge after the write edge
    task automatic outs(input logic [6:0] m, input logic [4:0] p);
        repeat (2) @(posedge clock);
        #1;
        chk("mac_cfg", {25'h0, mac_cfg}, {25'h0, m});
        chk("pads", {27'h0, ig_dly, eg_dly, rxc_oe, txc_oe, ib_en},
            {27'h0, p});
        @(posedge clock);
    endtask : outs

    // Reset, then wait for strap load
    task automatic do_reset;
        arst_n <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        chk("pready in reset", {31'h0, pready}, 32'h0);
        chk("mac_cfg in reset", {25'h0, mac_cfg}, 32'h0);
        @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : do_reset

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // Watchdog, far beyond the expected run of about 600 cycles
    initial
    begin
        #400000;
        bad_count++;
        final_report;
    end

    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        strap_gig = 1'b0;
        strap_role = 1'b1;
        strap_iface = IFACE_RGMII;
        in_frame = 1'b0;
        word = 4'h0;
        do_reset;
        outs(7'h47, 5'h09);
        rdc("link_control", LINK_CONTROL_ADDR, 32'h50, 1'b0);
        rdc("iface_sel", INTERFACE_SELECT_ADDR, 32'h0F, 1'b0);
        rdc("inband", INBAND_STATUS_ADDR, 32'h00, 1'b0);
        $display("test reset done");
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            outs(rows[i].mac, rows[i].pads);
            rdc("row readback", rows[i].addr, rows[i].rdata, 1'b0);
        end
        $display("test rows done");
        // In-band words taken only between frames
        foreach (ib_words[i])
        begin
            word <= ib_words[i];
            repeat (60) @(posedge clock);
            rdc("inband", INBAND_STATUS_ADDR, {28'h0, ib_words[i]},
                1'b0);
        end
        in_frame <= 1'b1;
        word <= 4'h3;
        repeat (60) @(posedge clock);
        rdc("inband frame", INBAND_STATUS_ADDR, 32'h08, 1'b0);
        in_frame <= 1'b0;
        repeat (60) @(posedge clock);
        rdc("inband idle", INBAND_STATUS_ADDR, 32'h03, 1'b0);
        // Upper nibble is storage, lower nibble read-only
        wr(INBAND_STATUS_ADDR, 8'hAC);
        rdc("inband ro", INBAND_STATUS_ADDR, 32'hA3, 1'b0);
        // Disabled reception holds the last word
        wr(INTERFACE_SELECT_ADDR, 8'h03);
        // Let the disable cross into the link domain before the new word
        repeat (20) @(posedge clock);
        word <= 4'hD;
        repeat (60) @(posedge clock);
        rdc("inband held", INBAND_STATUS_ADDR, 32'hA3, 1'b0);
        $display("test inband done");
        // Strobe off, unmapped places, then back-to-back transfers
        apb(1'b1, LINK_CONTROL_ADDR, 8'hFF, 4'h0);
        idle;
        rdc("no strobe", LINK_CONTROL_ADDR, 32'h10, 1'b0);
        apb(1'b1, 16'hCC08, 8'hFF, 4'h1);
        idle;
        chk("unmapped wr err", {31'h0, err}, 32'h1);
        rdc("unmapped", 16'hCC08, 32'h0, 1'b1);
        apb(1'b1, LINK_CONTROL_ADDR, 8'h40, 4'h1);
        apb(1'b1, INTERFACE_SELECT_ADDR, 8'h4F, 4'h1);
        apb(1'b0, LINK_CONTROL_ADDR, 8'h00, 4'h0);
        idle;
        chk("b2b read", rd, 32'h40);
        outs(7'h4B, 5'h09);
        $display("test refusals done");
        // Other straps give other reset values
        strap_gig <= 1'b1;
        strap_role <= 1'b0;
        strap_iface <= IFACE_RMII;
        do_reset;
        outs(7'h49, 5'h0C);
        rdc("iface_sel", INTERFACE_SELECT_ADDR, 32'h49, 1'b0);
        rdc("link_control", LINK_CONTROL_ADDR, 32'h50, 1'b0);
        $display("test straps done");
        final_report;
    end
endmodule : tb_host_port_media_config
